/* pkg/sensor_i2c_pkg.sv */
/*
 * Shared constants and types of the sensor register block:
 * register offsets, field positions, reset values, timing counts,
 * state encodings and the state carriers.
 * Assumes a 250 MHz core clock.
 */
package sensor_i2c_pkg;
    localparam logic [6:0] SLAVE_ADDR     = 7'h6D;
    localparam logic [7:0] REG_PRESS_HI   = 8'h06;
    localparam logic [7:0] REG_PRESS_MID  = 8'h07;
    localparam logic [7:0] REG_PRESS_LO   = 8'h08;
    localparam logic [7:0] REG_TEMP_HI    = 8'h09;
    localparam logic [7:0] REG_TEMP_LO    = 8'h0A;
    localparam logic [7:0] REG_CMD        = 8'h30;
    localparam logic [7:0] REG_SYS        = 8'hA5;
    localparam logic [7:0] REG_PATH       = 8'hA6;
    localparam logic [7:0] CMD_RST        = 8'h00;
    localparam logic [7:0] SYS_RST        = 8'h01;
    localparam logic [7:0] PATH_RST       = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA  = 8'h00;
    localparam int         CMD_SCO_BIT    = 3;
    localparam int         CMD_IDLE_LSB   = 4;
    localparam logic [2:0] MODE_SINGLE    = 3'h2;
    localparam logic [2:0] MODE_SLEEP     = 3'h3;
    localparam int         SYS_AOUT_LSB   = 4;
    localparam int         SYS_LDO_BIT    = 3;
    localparam int         SYS_UNI_BIT    = 2;
    localparam int         SYS_RAW_BIT    = 1;
    localparam int         SYS_DIAG_BIT   = 0;
    localparam int         PATH_SWAP_BIT  = 6;
    localparam int         PATH_GAIN_LSB  = 3;
    localparam int         PATH_OSR_LSB   = 0;
    localparam int         CLK_PERIOD_NS  = 4;
    localparam int         IDLE_STEP_NS   = 62_500_000;
    localparam int         IDLE_STEP_CYC  = IDLE_STEP_NS / CLK_PERIOD_NS;
    localparam int         CONV_PHASE_NS  = 1_000_000;
    localparam int         CONV_PHASE_CYC = CONV_PHASE_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'h0,
        BUS_RX   = 3'h1,
        BUS_ACK  = 3'h3,
        BUS_TX   = 3'h2,
        BUS_MACK = 3'h6,
        BUS_LOAD = 3'h7
    } bus_st_e;

    typedef enum logic [1:0] {
        BYTE_ADDR = 2'h0,
        BYTE_REG  = 2'h1,
        BYTE_DATA = 2'h3
    } byte_kind_e;

    typedef enum logic [1:0] {
        CONV_IDLE  = 2'h0,
        CONV_TEMP  = 2'h1,
        CONV_PRESS = 2'h3,
        CONV_SLEEP = 2'h2
    } conv_st_e;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic tog;
        logic bit_val;
    } link_s;

    typedef struct packed {
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_d;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_d;
        logic        tog_s1;
        logic        tog_s2;
        logic        tog_d;
        bus_st_e     bus_st;
        byte_kind_e  kind;
        logic        rw;
        logic        ack_on;
        logic [2:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  ptr;
        logic        sda_oe;
        logic        sda_lvl;
        logic [7:0]  cmd;
        logic [7:0]  sys;
        logic [7:0]  path;
        logic [23:0] press;
        logic [15:0] temp;
        conv_st_e    conv_st;
        logic [27:0] tmr;
        logic        conv_temp;
        logic        conv_press;
        logic [7:0]  gain;
        logic [3:0]  osr_log2;
    } core_s;
endpackage

/* rtl/sensor_i2c_regs.sv */
/*
 * I2C slave register interface of the pressure/temperature sensor,
 * with the conversion sequencer that fills the result registers.
 * Assumes open-drain SDA resolved outside, SCL used as the link clock,
 * and front-end results presented on plain inputs in the core domain.
 */
`timescale 1ns/100ps
// Overview of operation
// [RULE1] Answer at seven-bit address 0x6D
// [RULE2] Master start: SDA falls, SCL high
// [RULE3] Seven address bits, then direction bit
// [RULE4] Acknowledge own address, SDA low ninth
// [RULE5] Master stop: SDA rises, SCL high
// [RULE6] SDA changes only while SCL low
// [RULE7] Pressure bytes at 0x06..0x08, reset zero
// [RULE8] Temperature bytes at 0x09, 0x0A, reset zero
// [RULE9] Idle field sets sleep pause, 62.5 ms
// [RULE10] Go bit starts; self-clears except sleep
// [RULE11] Code 010: temperature then pressure conversion
// [RULE12] Code 011: repeated conversions with idle pause
// [RULE13] Regulator bit picks 1.8 V or 3.6 V
// [RULE14] Unsigned bit applies only to raw output
// [RULE15] Raw bit picks raw over calibrated results
// [RULE16] Self-check bit enables diagnosis, default on
// [RULE17] Swap bit exchanges sensor input polarity
// [RULE18] Gain field is two to the code
// [RULE19] Oversample field maps codes to ratios
// [RULE20] Host leaves analog output field alone
// [RULE21] Host writes 0x0A, polls or waits
// [RULE22] Pressure MSB is the sign bit
// [RULE23] Write: addr, register, data; read: restart
module sensor_i2c_regs
    import sensor_i2c_pkg::*;
#(
    parameter int CONV_PHASE_CYCLES = CONV_PHASE_CYC,
    parameter int IDLE_STEP_CYCLES  = IDLE_STEP_CYC
) (
    // Core clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    // I2C pins; SCL also clocks the link sampler
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // Front-end results, core domain
    input  wire logic [23:0] press_cal_i,
    input  wire logic [23:0] press_raw_i,
    input  wire logic [15:0] temp_i,
    // Front-end controls
    output logic             regulator_level_sel_o,
    output logic             self_check_en_o,
    output logic             input_swap_o,
    output logic [7:0]       gain_o,
    output logic [3:0]       oversample_ratio_o,
    output logic             conv_temp_o,
    output logic             conv_press_o
);

    link_s lr;
    link_s ln;
    core_s r;
    core_s n;

    function automatic logic [7:0] read_reg(input logic [7:0] a, input core_s s);
        case (a)
            // [RULE7] pressure bytes
            REG_PRESS_HI:  read_reg = s.press[23:16];
            REG_PRESS_MID: read_reg = s.press[15:8];
            REG_PRESS_LO:  read_reg = s.press[7:0];
            // [RULE8] temperature bytes
            REG_TEMP_HI:   read_reg = s.temp[15:8];
            REG_TEMP_LO:   read_reg = s.temp[7:0];
            REG_CMD:       read_reg = s.cmd;
            REG_SYS:       read_reg = s.sys;
            REG_PATH:      read_reg = s.path;
            // Unmapped: fixed value
            default:       read_reg = UNMAPPED_DATA;
        endcase
    endfunction

    // Fifteen default steps fit in 28 bits
    function automatic logic [27:0] idle_cycles(input logic [3:0] code);
        idle_cycles = 28'(int'(code) * IDLE_STEP_CYCLES);
    endfunction

    // Link side: one bit per SCL rise, handed over by toggle
    // Link reset ends only after two SCL rises;
    // host clocks SCL idle before a start
    always_comb begin
        ln        = lr;
        ln.rst_s1 = srst_i;
        ln.rst_s2 = lr.rst_s1;
        if (lr.rst_s2) begin
            ln.tog     = 1'b0;
            ln.bit_val = 1'b0;
        end else begin
            ln.tog     = ~lr.tog;
            ln.bit_val = sda_i;
        end
    end

    always_ff @(posedge scl_i) begin
        lr <= ln;
    end

    // Line events
    logic start_det;
    logic stop_det;
    logic bit_evt;
    logic scl_fall;
    logic [7:0] rx_byte;
    logic cmd_wr;
    logic [7:0] cmd_wdata;

    always_comb begin
        n         = r;
        n.scl_s1  = scl_i;
        n.scl_s2  = r.scl_s1;
        n.scl_d   = r.scl_s2;
        n.sda_s1  = sda_i;
        n.sda_s2  = r.sda_s1;
        n.sda_d   = r.sda_s2;
        n.tog_s1  = lr.tog;
        n.tog_s2  = r.tog_s1;
        n.tog_d   = r.tog_s2;
        n.sda_lvl = 1'b0;
        // [RULE2] start seen as SDA fall with SCL high
        start_det = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
        // [RULE5] stop seen as SDA rise with SCL high
        stop_det  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
        bit_evt   = r.tog_s2 ^ r.tog_d;
        scl_fall  = r.scl_d & ~r.scl_s2;
        rx_byte   = {r.sh[6:0], lr.bit_val};
        cmd_wr    = 1'b0;
        cmd_wdata = rx_byte;

        case (r.bus_st)
            // Wait for a start
            BUS_IDLE: begin
            end

            BUS_RX: begin
                if (bit_evt) begin
                    // MSB first
                    n.sh  = rx_byte;
                    n.cnt = r.cnt + 3'h1;
                    if (r.cnt == 3'h7) begin
                        n.bus_st = BUS_ACK;
                        case (r.kind)
                            BYTE_ADDR: begin
                                // [RULE1] [RULE3] match address, keep direction
                                n.rw = rx_byte[0];
                                if (rx_byte[7:1] != SLAVE_ADDR) begin
                                    n.bus_st = BUS_IDLE;
                                end
                            end
                            BYTE_REG: begin
                                // [RULE23] register address byte
                                n.ptr = rx_byte;
                            end
                            default: begin
                                n.ptr = r.ptr + 8'h01;
                                case (r.ptr)
                                    REG_CMD:  cmd_wr = 1'b1;
                                    REG_SYS:  n.sys  = rx_byte;
                                    REG_PATH: n.path = rx_byte;
                                    default: begin
                                    end
                                endcase
                            end
                        endcase
                    end
                end
            end

            BUS_ACK: begin
                // [RULE4] [RULE6] drive low from the fall after bit 8
                if (scl_fall) begin
                    if (!r.ack_on) begin
                        n.ack_on = 1'b1;
                        n.sda_oe = 1'b1;
                    end else begin
                        n.ack_on = 1'b0;
                        n.sda_oe = 1'b0;
                        n.cnt    = 3'h0;
                        if (r.kind == BYTE_ADDR && r.rw) begin
                            n.bus_st = BUS_TX;
                            n.sh     = read_reg(r.ptr, r);
                            n.sda_oe = ~n.sh[7];
                            n.ptr    = r.ptr + 8'h01;
                        end else begin
                            n.bus_st = BUS_RX;
                            n.kind   = (r.kind == BYTE_ADDR) ? BYTE_REG : BYTE_DATA;
                        end
                    end
                end
            end

            // Bit out after each fall
            BUS_TX: begin
                if (bit_evt) begin
                    n.cnt = r.cnt + 3'h1;
                    if (r.cnt == 3'h7) begin
                        n.bus_st = BUS_MACK;
                    end
                end else if (scl_fall && r.cnt != 3'h0) begin
                    // [RULE6] next bit only while SCL low
                    n.sh     = {r.sh[6:0], 1'b0};
                    n.sda_oe = ~r.sh[6];
                end
            end

            // Low ninth bit: one more byte
            BUS_MACK: begin
                if (scl_fall) begin
                    n.sda_oe = 1'b0;
                end
                if (bit_evt) begin
                    n.bus_st = lr.bit_val ? BUS_IDLE : BUS_LOAD;
                end
            end

            BUS_LOAD: begin
                if (scl_fall) begin
                    n.bus_st = BUS_TX;
                    n.cnt    = 3'h0;
                    n.sh     = read_reg(r.ptr, r);
                    n.sda_oe = ~n.sh[7];
                    n.ptr    = r.ptr + 8'h01;
                end
            end

            default: begin
                n.bus_st = BUS_IDLE;
            end
        endcase

        // Start and stop override any byte in flight
        if (start_det) begin
            n.bus_st = BUS_RX;
            n.kind   = BYTE_ADDR;
            n.cnt    = 3'h0;
            n.ack_on = 1'b0;
            n.sda_oe = 1'b0;
        end else if (stop_det) begin
            n.bus_st = BUS_IDLE;
            n.ack_on = 1'b0;
            n.sda_oe = 1'b0;
        end

        case (r.conv_st)
            // Only a host write starts
            CONV_IDLE: begin
            end

            // [RULE11] temperature phase first
            CONV_TEMP: begin
                n.tmr = r.tmr + 28'h1;
                if (r.tmr == 28'(CONV_PHASE_CYCLES - 1)) begin
                    n.tmr     = 28'h0;
                    n.temp    = temp_i;
                    n.conv_st = CONV_PRESS;
                end
            end

            CONV_PRESS: begin
                n.tmr = r.tmr + 28'h1;
                if (r.tmr == 28'(CONV_PHASE_CYCLES - 1)) begin
                    n.tmr = 28'h0;
                    // [RULE15] [RULE14] [RULE22] result format
                    if (!r.sys[SYS_RAW_BIT]) begin
                        n.press = press_cal_i;
                    end else if (r.sys[SYS_UNI_BIT]) begin
                        n.press = {~press_raw_i[23], press_raw_i[22:0]};
                    end else begin
                        n.press = press_raw_i;
                    end
                    // [RULE12] [RULE10] sleep keeps go bit set
                    if (r.cmd[2:0] == MODE_SLEEP) begin
                        n.conv_st = CONV_SLEEP;
                    end else begin
                        n.conv_st          = CONV_IDLE;
                        n.cmd[CMD_SCO_BIT] = 1'b0;
                    end
                end
            end

            CONV_SLEEP: begin
                // [RULE9] pause of idle code steps
                n.tmr = r.tmr + 28'h1;
                if (r.tmr >= idle_cycles(r.cmd[7:CMD_IDLE_LSB])) begin
                    n.tmr     = 28'h0;
                    n.conv_st = CONV_TEMP;
                end
            end
            default: begin
                n.conv_st = CONV_IDLE;
            end
        endcase

        // A host write lands after the self-clear, so a new go bit wins
        if (cmd_wr) begin
            n.cmd = cmd_wdata;
            n.tmr = 28'h0;
            // [RULE10] [RULE11] [RULE12] go bit starts a run
            if (cmd_wdata[CMD_SCO_BIT] &&
                (cmd_wdata[2:0] == MODE_SINGLE || cmd_wdata[2:0] == MODE_SLEEP)) begin
                n.conv_st = CONV_TEMP;
            end else begin
                n.conv_st          = CONV_IDLE;
                n.cmd[CMD_SCO_BIT] = 1'b0;
            end
        end

        // Flags from flops
        n.conv_temp  = (n.conv_st == CONV_TEMP);
        n.conv_press = (n.conv_st == CONV_PRESS);
        // [RULE18] gain is two to the code
        n.gain = 8'h01 << n.path[PATH_GAIN_LSB +: 3];
        // [RULE19] oversample code to log2 ratio
        case (n.path[PATH_OSR_LSB +: 3])
            3'h0:    n.osr_log2 = 4'hA;
            3'h1:    n.osr_log2 = 4'hB;
            3'h2:    n.osr_log2 = 4'hC;
            3'h3:    n.osr_log2 = 4'hD;
            3'h4:    n.osr_log2 = 4'h8;
            3'h5:    n.osr_log2 = 4'h9;
            3'h6:    n.osr_log2 = 4'hE;
            default: n.osr_log2 = 4'hF;
        endcase

        // Reset wins
        if (srst_i) begin
            n          = '0;
            n.bus_st   = BUS_IDLE;
            n.kind     = BYTE_ADDR;
            n.conv_st  = CONV_IDLE;
            n.scl_s1   = 1'b1;
            n.scl_s2   = 1'b1;
            n.scl_d    = 1'b1;
            n.sda_s1   = 1'b1;
            n.sda_s2   = 1'b1;
            n.sda_d    = 1'b1;
            n.cmd      = CMD_RST;
            n.sys      = SYS_RST;
            n.path     = PATH_RST;
            n.gain     = 8'h01;
            n.osr_log2 = 4'hA;
        end
    end

    always_ff @(posedge core_clk_i) begin
        r <= n;
    end

    // Pin only pulled low
    assign sda_o    = r.sda_lvl;
    assign sda_oe_o = r.sda_oe;
    // [RULE13] regulator level select
    assign regulator_level_sel_o = r.sys[SYS_LDO_BIT];
    // [RULE16] diagnosis enable, on after reset
    assign self_check_en_o = r.sys[SYS_DIAG_BIT];
    // [RULE17] input polarity exchange
    assign input_swap_o       = r.path[PATH_SWAP_BIT];
    // Front-end settings
    assign gain_o             = r.gain;
    assign oversample_ratio_o = r.osr_log2;
    assign conv_temp_o        = r.conv_temp;
    assign conv_press_o       = r.conv_press;

endmodule

/* tb/sensor_regs_monitor.sv */
/*
 * Port checker of the sensor register block, bound into it.
 * Assumes SCL phases far longer than a core clock cycle.
 */
`timescale 1ns/100ps
module sensor_regs_monitor
    import sensor_i2c_pkg::*;
#(
    parameter int CONV_PHASE_CYCLES = CONV_PHASE_CYC,
    parameter int IDLE_STEP_CYCLES  = IDLE_STEP_CYC
) (
    // Clock and reset
    input wire logic       core_clk_i,
    input wire logic       srst_i,
    // Bus pins
    input wire logic       scl_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    // Front-end controls
    input wire logic       regulator_level_sel_o,
    input wire logic       self_check_en_o,
    input wire logic       input_swap_o,
    input wire logic [7:0] gain_o,
    input wire logic [3:0] oversample_ratio_o,
    input wire logic       conv_temp_o,
    input wire logic       conv_press_o
);
    logic [31:0] len_reg;
    logic [31:0] len_next;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);
    // Length of the running temperature phase
    always_comb begin
        len_next = conv_temp_o ? len_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge core_clk_i) begin
        len_reg <= srst_i ? 32'h0 : len_next;
    end
    a_open_drain_pin: assert property (sda_o == 1'b0)
        else $error("sda output not low");
    a_ack_steady_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("sda drive moved while scl high");
    a_ack_starts_low: assert property ($rose(sda_oe_o) |-> !scl_i ##1 !scl_i)
        else $error("sda drive began near scl high");
    a_reset_defaults: assert property ($fell(srst_i) |->
        self_check_en_o && !regulator_level_sel_o && !input_swap_o && gain_o == 8'h01
        && oversample_ratio_o == 4'hA && !sda_oe_o) else $error("wrong outputs after reset");
    a_gain_power_two: assert property ($onehot(gain_o))
        else $error("gain not a power of two");
    a_ratio_in_range: assert property (oversample_ratio_o >= 4'h8)
        else $error("oversample ratio out of range");
    a_phase_exclusive: assert property (!(conv_temp_o && conv_press_o))
        else $error("both phases active");
    a_temp_then_press: assert property ($fell(conv_temp_o) |->
        conv_press_o && len_reg == CONV_PHASE_CYCLES) else $error("temperature phase wrong");
    a_press_after_temp: assert property ($rose(conv_press_o) |-> $past(conv_temp_o))
        else $error("pressure phase without temperature");
    a_pause_after_press: assert property ($fell(conv_press_o) |-> !conv_temp_o)
        else $error("no pause after pressure phase");
endmodule

bind sensor_i2c_regs sensor_regs_monitor #(
    .CONV_PHASE_CYCLES(CONV_PHASE_CYCLES), .IDLE_STEP_CYCLES(IDLE_STEP_CYCLES)
) monitor_inst (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .regulator_level_sel_o(regulator_level_sel_o),
    .self_check_en_o(self_check_en_o), .input_swap_o(input_swap_o), .gain_o(gain_o),
    .oversample_ratio_o(oversample_ratio_o), .conv_temp_o(conv_temp_o),
    .conv_press_o(conv_press_o)
);

/* tb/i2c_host_model.sv */
/*
 * Behavioural I2C bus master for the sensor register block.
 * Assumes pull-ups on both lines; SCL stands high between frames.
 */
`timescale 1ns/100ps
module i2c_host_model
    import sensor_i2c_pkg::*;
(
    // Link clock and resolved data line
    input  wire logic lclk_i,
    input  wire logic sda_i,
    // Driven lines, 1 releases to the pull-up
    output logic      scl_o,
    output logic      sda_drv_o
);
    initial begin
        scl_o = 1'b1;
        sda_drv_o = 1'b1;
    end
    // Three link cycles keep each SCL phase above eight core cycles
    task automatic tick();
        repeat (3) @(posedge lclk_i);
    endtask
    // Clocks the link sampler through its reset
    task automatic idle_clocks(input int n);
        repeat (n) begin
            tick();
            scl_o <= 1'b0;
            tick();
            scl_o <= 1'b1;
        end
    endtask
    // Data falls with clock high, also as restart
    task automatic start();
        tick();
        sda_drv_o <= 1'b1;
        tick();
        scl_o <= 1'b1;
        tick();
        sda_drv_o <= 1'b0;
        tick();
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        tick();
        sda_drv_o <= 1'b0;
        tick();
        scl_o <= 1'b1;
        tick();
        sda_drv_o <= 1'b1;
        tick();
    endtask
    // Data moves only while clock low
    task automatic bit_io(input logic b, output logic r);
        tick();
        sda_drv_o <= b;
        tick();
        scl_o <= 1'b1;
        tick();
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    // Eight bits MSB first, then the ninth
    task automatic byte_io(input logic [8:0] d, output logic [8:0] s);
        for (int i = 8; i >= 0; i--) begin
            bit_io(d[i], s[i]);
        end
    endtask
    // Write: address, register, data; read: restart, byte, NACK
    task automatic xfer(input logic [6:0] ad, input logic rd, input logic [7:0] r,
                        input logic [7:0] d, output logic [7:0] q, output logic [2:0] acks);
        logic [8:0] s;
        start();
        byte_io({ad, 2'b01}, s);
        acks[2] = s[0];
        byte_io({r, 1'b1}, s);
        acks[1] = s[0];
        if (rd) begin
            start();
            byte_io({ad, 2'b11}, s);
            acks[0] = s[0];
            byte_io(9'h1FF, s);
            q = s[8:1];
        end else begin
            byte_io({d, 1'b1}, s);
            acks[0] = s[0];
            q = 8'h00;
        end
        stop();
    endtask
endmodule

/* tb/tb.sv */
/*
 * Self-checking bench of the sensor register block: host model, front-end
 * stimulus and a register model compared at every result.
 * Assumes the checker binds itself into the design.
 */
`timescale 1ns/100ps
module tb;
    import sensor_i2c_pkg::*;
    localparam int CONV = 20;
    localparam int IDLE = 10;
    logic        core_clk_i, lclk, srst_i, scl, sda_drv, sda_oe, sda_out;
    logic        lvl_sel, chk_en, swap, ct, cp;
    logic [23:0] press_cal, press_raw;
    logic [15:0] temp;
    logic [7:0]  gain, q;
    logic [3:0]  osr;
    logic [2:0]  acks;
    logic [7:0]  mregs [0:255];
    logic [7:0]  osr_log [0:7] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h08, 8'h09, 8'h0E, 8'h0F};
    logic [7:0]  addrs [0:8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h30, 8'hA5, 8'hA6, 8'h55};
    logic [7:0]  sys_tab [0:3] = '{8'h01, 8'h03, 8'h07, 8'h05};
    int          bad_count, tests_run, n;

    sensor_i2c_regs #(.CONV_PHASE_CYCLES(CONV), .IDLE_STEP_CYCLES(IDLE)) sensor_i2c_regs_inst (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_drv & ~sda_oe),
        .sda_o(sda_out), .sda_oe_o(sda_oe), .press_cal_i(press_cal), .press_raw_i(press_raw),
        .temp_i(temp), .regulator_level_sel_o(lvl_sel), .self_check_en_o(chk_en),
        .input_swap_o(swap), .gain_o(gain), .oversample_ratio_o(osr), .conv_temp_o(ct),
        .conv_press_o(cp));
    i2c_host_model host_inst (.lclk_i(lclk), .sda_i(sda_drv & ~sda_oe), .scl_o(scl),
        .sda_drv_o(sda_drv));

    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial begin
        lclk = 1'b0;
        #1.7;
        forever #6 lclk = ~lclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic fail_now(input string what);
        bad_count++;
        $display("mismatch %s expected done seen timeout", what);
        print_verdict();
    endtask
    task automatic check8(input string what, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        host_inst.xfer(SLAVE_ADDR, 1'b0, r, d, q, acks);
        check8("write acks", 8'h00, {5'h00, acks});
        if (r == REG_CMD || r == REG_SYS || r == REG_PATH) begin
            mregs[r] = d;
        end
    endtask
    task automatic rd(input logic [7:0] r);
        host_inst.xfer(SLAVE_ADDR, 1'b1, r, 8'h00, q, acks);
        check8("read acks", 8'h00, {5'h00, acks});
        check8($sformatf("register %h", r), mregs[r], q);
    endtask
    task automatic chk_outs();
        check8("levels", {5'h00, mregs[REG_SYS][SYS_LDO_BIT], mregs[REG_SYS][SYS_DIAG_BIT],
            mregs[REG_PATH][PATH_SWAP_BIT]}, {5'h00, lvl_sel, chk_en, swap});
        check8("gain", 8'h01 << mregs[REG_PATH][5:3], gain);
        check8("oversample", osr_log[mregs[REG_PATH][2:0]], {4'h0, osr});
    endtask
    // Unsigned form flips the sign bit of raw pressure only
    task automatic conv_model();
        logic [7:0] s;
        s = mregs[REG_SYS];
        {mregs[6], mregs[7], mregs[8]} = s[SYS_RAW_BIT] ?
            press_raw ^ {s[SYS_UNI_BIT], 23'h0} : press_cal;
        {mregs[9], mregs[10]} = temp;
        if (mregs[REG_CMD][2:0] == MODE_SINGLE) begin
            mregs[REG_CMD][CMD_SCO_BIT] = 1'b0;
        end
    endtask
    task automatic poll();
        for (int i = 0; i < 20; i++) begin
            host_inst.xfer(SLAVE_ADDR, 1'b1, REG_CMD, 8'h00, q, acks);
            if (q[CMD_SCO_BIT] === 1'b0) begin
                return;
            end
        end
        fail_now("conversion");
    endtask
    task automatic wait_lvl(input logic sel, input logic lvl);
        n = 0;
        while ((sel ? cp : ct) !== lvl) begin
            @(negedge core_clk_i);
            n++;
            if (n > 3000) begin
                fail_now("phase");
            end
        end
    endtask

    initial begin
        repeat (95000) @(posedge core_clk_i);
        fail_now("run");
    end
    initial begin
        srst_i = 1'b1;
        press_cal = 24'h000000;
        press_raw = 24'h000000;
        temp = 16'h0000;
        bad_count = 0;
        tests_run = 0;
        for (int i = 0; i < 256; i++) begin
            mregs[i] = 8'h00;
        end
        mregs[REG_SYS] = SYS_RST;
        void'($urandom(62));
        host_inst.idle_clocks(4);
        repeat (20) @(posedge core_clk_i);
        srst_i <= 1'b0;
        host_inst.idle_clocks(2); // Clears the link reset
        repeat (8) @(posedge core_clk_i);
        foreach (addrs[i]) begin
            rd(addrs[i]);
        end
        chk_outs();
        wr(REG_PRESS_MID, 8'h5A);
        wr(8'h55, 8'hC3);
        rd(REG_PRESS_MID);
        rd(8'h55);
        host_inst.xfer(7'h6C, 1'b0, REG_SYS, 8'h0F, q, acks);
        check8("foreign acks", 8'h07, {5'h00, acks});
        rd(REG_SYS);
        $display("test reset_and_access done");
        for (int c = 0; c < 8; c++) begin
            wr(REG_PATH, {c[1:0], c[2:0], 3'(7 - c)});
            wr(REG_SYS, {4'h0, 4'(c * 5 + 1)});
            chk_outs();
            rd(REG_PATH);
        end
        $display("test field_codes done");
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk_i);
            press_cal <= 24'($urandom);
            press_raw <= 24'($urandom);
            temp <= 16'($urandom);
            wr(REG_SYS, sys_tab[k]);
            wr(REG_CMD, 8'h0A);
            conv_model();
            poll();
            for (int r = 6; r <= 10; r++) begin
                rd(8'(r));
            end
            rd(REG_CMD);
        end
        $display("test single_conversion done");
        wr(REG_CMD, 8'h2B);
        wait_lvl(1'b1, 1'b1);
        wait_lvl(1'b1, 1'b0);
        wait_lvl(1'b0, 1'b1);
        check8("sleep gap", 8'h01, {7'h00, n >= 2 * IDLE && n <= 2 * IDLE + 2});
        rd(REG_CMD);
        $display("test sleep_mode done");
        print_verdict();
    end
endmodule
